/* rtl/ddrmr_consts.svh */
// Offsets, field positions, reset values and timing counts of the first mode register.
// Assumes inclusion by bare name from rtl/ files; definitions only.
`ifndef DDRMR_CONSTS_SVH
`define DDRMR_CONSTS_SVH

`define DDRMR_ADDR_W 14
`define DDRMR_BANK_SEL 3'h0
`define DDRMR_RESET_VAL 14'h0050
`define DDRMR_BL_LSB 0
`define DDRMR_BL_MSB 1
`define DDRMR_CL_LOW_BIT 2
`define DDRMR_RBT_BIT 3
`define DDRMR_CL_LSB 4
`define DDRMR_CL_MSB 6
`define DDRMR_TM_BIT 7
`define DDRMR_DLL_BIT 8
`define DDRMR_WR_LSB 9
`define DDRMR_WR_MSB 11
`define DDRMR_PPD_BIT 12
`define DDRMR_CHOP_BIT 12
`define DDRMR_LAT_DEFAULT 5'h09
`define DDRMR_WR_DEFAULT 5'h10
`define DDRMR_COL_SPACING_NCK 3'h4
`define DDRMR_LOCK_NCK 512
`define DDRMR_LAT_MAX 16

`endif

/* rtl/ddrmr_pkg.sv */
// Types shared by the mode register decode and its top.
// Assumes ddrmr_consts.svh sits beside it.
`include "ddrmr_consts.svh"

package ddrmr_pkg;

  typedef logic [`DDRMR_ADDR_W-1:0] ddrmr_word_t;

  typedef enum logic [1:0] {
    DDRMR_FIXED_EIGHT = 2'h0,
    DDRMR_PER_CMD = 2'h1,
    DDRMR_FIXED_FOUR = 2'h2,
    DDRMR_FIXED_EIGHT_ALT = 2'h3
  } ddrmr_burst_t;

  typedef enum logic [3:0] {
    DDRMR_LOOP_IDLE = 4'h1,
    DDRMR_LOOP_RESTART = 4'h2,
    DDRMR_LOOP_LOCKING = 4'h4,
    DDRMR_LOOP_LOCKED = 4'h8
  } ddrmr_loop_t;

endpackage

/* rtl/ddrmr_fields_if.sv */
// Decoded fields passed from the decoder to the top.
// Assumes ddrmr_pkg is compiled first.
`timescale 1ns/1ps

interface ddrmr_fields_if;
  ddrmr_pkg::ddrmr_burst_t burst_mode;
  logic read_interleave;
  logic [4:0] read_latency;
  logic [4:0] write_recovery;
  logic test_mode;
  logic fast_exit;
  logic restart_req;

  modport source (
    output burst_mode, read_interleave, read_latency, write_recovery,
    output test_mode, fast_exit, restart_req
  );
  modport sink (
    input burst_mode, read_interleave, read_latency, write_recovery,
    input test_mode, fast_exit, restart_req
  );
endinterface

/* rtl/ddrmr_decode.sv */
// Pure decode of the stored mode word into its fields.
// Assumes the word is held stable by the top between writes.
`timescale 1ns/1ps
`include "ddrmr_consts.svh"

module ddrmr_decode (
  input wire ddrmr_pkg::ddrmr_word_t mode_word,
  ddrmr_fields_if.source fields
);
  import ddrmr_pkg::*;

  function automatic logic [4:0] lat_decode(input logic [3:0] code);
    logic [4:0] lat;
    lat = `DDRMR_LAT_DEFAULT;
    case (code)
      4'h2: lat = 5'h05;
      4'h4: lat = 5'h06;
      4'h6: lat = 5'h07;
      4'h8: lat = 5'h08;
      4'ha: lat = 5'h09;
      4'hc: lat = 5'h0a;
      4'he: lat = 5'h0b;
      4'h1: lat = 5'h0c;
      4'h3: lat = 5'h0d;
      4'h5: lat = 5'h0f;
      4'h9: lat = 5'h10;
      default: lat = `DDRMR_LAT_DEFAULT;
    endcase
    return lat;
  endfunction

  function automatic logic [4:0] wr_decode(input logic [2:0] code);
    logic [4:0] wr;
    wr = `DDRMR_WR_DEFAULT;
    case (code)
      3'h1: wr = 5'h05;
      3'h2: wr = 5'h06;
      3'h3: wr = 5'h07;
      3'h4: wr = 5'h08;
      3'h5: wr = 5'h0c;
      3'h7: wr = 5'h0e;
      default: wr = `DDRMR_WR_DEFAULT;
    endcase
    return wr;
  endfunction

  wire [3:0] lat_code = {mode_word[`DDRMR_CL_MSB:`DDRMR_CL_LSB], mode_word[`DDRMR_CL_LOW_BIT]};

  assign fields.burst_mode = ddrmr_burst_t'(mode_word[`DDRMR_BL_MSB:`DDRMR_BL_LSB]);
  assign fields.read_interleave = mode_word[`DDRMR_RBT_BIT];
  assign fields.read_latency = lat_decode(lat_code);
  assign fields.write_recovery = wr_decode(mode_word[`DDRMR_WR_MSB:`DDRMR_WR_LSB]);
  assign fields.test_mode = mode_word[`DDRMR_TM_BIT];
  assign fields.fast_exit = mode_word[`DDRMR_PPD_BIT];
  assign fields.restart_req = mode_word[`DDRMR_DLL_BIT];
endmodule

/* rtl/ddrmr_top.sv */
// First mode register of the memory: pin capture, field hold, burst sizing,
// read latency timing, loop restart and power-down loop control.
// Assumes command pins come from another clock domain; power-down requests come
// from logic on core_clk.
`timescale 1ns/1ps
`include "ddrmr_consts.svh"

module ddrmr_top #(
  parameter int LOCK_CYCLES = `DDRMR_LOCK_NCK,
  parameter int LAT_MAX = `DDRMR_LAT_MAX
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic [2:0] bank_addr,
  input wire ddrmr_pkg::ddrmr_word_t addr_pins,
  input wire logic precharge_pd,
  input wire logic active_pd,
  output logic [1:0] burst_mode_out,
  output logic read_interleave_out,
  output logic [4:0] read_latency_out,
  output logic [4:0] write_recovery_out,
  output logic test_mode_out,
  output ddrmr_pkg::ddrmr_word_t mode_word_out,
  output logic cmd_valid_out,
  output logic cmd_is_write_out,
  output logic cmd_burst_eight_out,
  output logic [2:0] col_spacing_out,
  output logic data_start_out,
  output logic data_burst_eight_out,
  output logic loop_restart_out,
  output logic loop_locked_out,
  output logic read_early_out,
  output logic loop_frozen_out,
  output logic slow_exit_out
);
  import ddrmr_pkg::*;

  localparam int PIN_W = 7 + `DDRMR_ADDR_W;
  localparam logic [9:0] LOCK_LAST = 10'(LOCK_CYCLES - 1);

  // Two-stage capture of all command and address pins
  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
    end else if (clk_en) begin
      pin_meta_r <= {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, bank_addr, addr_pins};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire cs_n_s = pin_sync_r[PIN_W-1];
  wire ras_n_s = pin_sync_r[PIN_W-2];
  wire cas_n_s = pin_sync_r[PIN_W-3];
  wire we_n_s = pin_sync_r[PIN_W-4];
  wire [2:0] bank_s = pin_sync_r[`DDRMR_ADDR_W+2:`DDRMR_ADDR_W];
  wire ddrmr_word_t addr_s = pin_sync_r[`DDRMR_ADDR_W-1:0];

  // Command decode
  wire mode_set_cmd = !cs_n_s && !ras_n_s && !cas_n_s && !we_n_s;
  wire mode_zero_write = mode_set_cmd && (bank_s == `DDRMR_BANK_SEL);
  wire column_cmd = !cs_n_s && ras_n_s && !cas_n_s;
  wire read_cmd = column_cmd && we_n_s;
  wire write_cmd = column_cmd && !we_n_s;

  // Stored mode word
  ddrmr_word_t mode_r;
  ddrmr_word_t mode_nxt;
  ddrmr_fields_if fields ();

  ddrmr_decode u_decode (
    .mode_word(mode_r),
    .fields(fields)
  );

  // A new write wins over the self-clear of the restart bit
  always_comb begin
    mode_nxt = mode_r;
    if (mode_zero_write) begin
      mode_nxt = addr_s;
    end else if (fields.restart_req) begin
      mode_nxt[`DDRMR_DLL_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_r <= `DDRMR_RESET_VAL;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
    end
  end

  // Burst size chosen at column command time
  logic cmd_eight_nxt;

  always_comb begin
    unique case (fields.burst_mode)
      DDRMR_FIXED_EIGHT: cmd_eight_nxt = 1'b1;
      DDRMR_PER_CMD: cmd_eight_nxt = addr_s[`DDRMR_CHOP_BIT];
      DDRMR_FIXED_FOUR: cmd_eight_nxt = 1'b0;
      DDRMR_FIXED_EIGHT_ALT: cmd_eight_nxt = 1'b1;
    endcase
  end

  wire [2:0] spacing_nxt = (fields.burst_mode == DDRMR_FIXED_FOUR) ?
    `DDRMR_COL_SPACING_NCK : 3'h0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_valid_out <= 1'b0;
      cmd_is_write_out <= 1'b0;
      cmd_burst_eight_out <= 1'b1;
    end else if (clk_en) begin
      cmd_valid_out <= column_cmd;
      if (column_cmd) begin
        cmd_is_write_out <= write_cmd;
        cmd_burst_eight_out <= cmd_eight_nxt;
      end
    end
  end

  // Read latency pipeline: bit k is high k+1 cycles after the read
  logic [LAT_MAX-1:0] read_pipe_r;
  logic [LAT_MAX-1:0] eight_pipe_r;
  wire [4:0] tap = 5'(fields.read_latency - 5'h02);
  wire data_start_nxt = read_pipe_r[tap[3:0]];
  wire data_eight_nxt = eight_pipe_r[tap[3:0]];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_pipe_r <= '0;
      eight_pipe_r <= '0;
    end else if (clk_en) begin
      read_pipe_r <= {read_pipe_r[LAT_MAX-2:0], read_cmd};
      eight_pipe_r <= {eight_pipe_r[LAT_MAX-2:0], read_cmd && cmd_eight_nxt};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_start_out <= 1'b0;
      data_burst_eight_out <= 1'b0;
    end else if (clk_en) begin
      data_start_out <= data_start_nxt;
      data_burst_eight_out <= data_start_nxt && data_eight_nxt;
    end
  end

  // Loop restart and lock tracking
  ddrmr_loop_t loop_r;
  ddrmr_loop_t loop_nxt;
  logic [9:0] lock_cnt_r;
  logic [9:0] lock_cnt_nxt;

  always_comb begin
    loop_nxt = loop_r;
    lock_cnt_nxt = lock_cnt_r;
    if (fields.restart_req) begin
      loop_nxt = DDRMR_LOOP_RESTART;
      lock_cnt_nxt = 10'h000;
    end else begin
      unique case (loop_r)
        DDRMR_LOOP_IDLE: loop_nxt = DDRMR_LOOP_IDLE;
        DDRMR_LOOP_RESTART: begin
          loop_nxt = DDRMR_LOOP_LOCKING;
          lock_cnt_nxt = 10'h000;
        end
        DDRMR_LOOP_LOCKING: begin
          if (loop_frozen_out) begin
            lock_cnt_nxt = lock_cnt_r;
          end else if (lock_cnt_r == LOCK_LAST) begin
            loop_nxt = DDRMR_LOOP_LOCKED;
          end else begin
            lock_cnt_nxt = 10'(lock_cnt_r + 10'h001);
          end
        end
        DDRMR_LOOP_LOCKED: loop_nxt = DDRMR_LOOP_LOCKED;
        default: loop_nxt = DDRMR_LOOP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      loop_r <= DDRMR_LOOP_IDLE;
      lock_cnt_r <= 10'h000;
    end else if (clk_en) begin
      loop_r <= loop_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  // Reads issued before lock are flagged; a late read wins over the restart clear
  wire read_early_nxt = (read_cmd && (loop_r != DDRMR_LOOP_LOCKED)) ||
    (read_early_out && !fields.restart_req);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      loop_restart_out <= 1'b0;
      loop_locked_out <= 1'b0;
      read_early_out <= 1'b0;
    end else if (clk_en) begin
      loop_restart_out <= fields.restart_req;
      loop_locked_out <= (loop_nxt == DDRMR_LOOP_LOCKED);
      read_early_out <= read_early_nxt;
    end
  end

  // Power-down loop behaviour: only precharge power-down looks at the exit bit
  wire frozen_nxt = precharge_pd && !active_pd && !fields.fast_exit;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      loop_frozen_out <= 1'b0;
      slow_exit_out <= 1'b0;
    end else if (clk_en) begin
      loop_frozen_out <= frozen_nxt;
      slow_exit_out <= !fields.fast_exit;
    end
  end

  // Registered copies of the held fields
  always_ff @(posedge core_clk) begin
    if (reset) begin
      burst_mode_out <= 2'h0;
      read_interleave_out <= 1'b0;
      read_latency_out <= `DDRMR_LAT_DEFAULT;
      write_recovery_out <= `DDRMR_WR_DEFAULT;
      test_mode_out <= 1'b0;
      mode_word_out <= `DDRMR_RESET_VAL;
      col_spacing_out <= 3'h0;
    end else if (clk_en) begin
      burst_mode_out <= fields.burst_mode;
      read_interleave_out <= fields.read_interleave;
      read_latency_out <= fields.read_latency;
      write_recovery_out <= fields.write_recovery;
      test_mode_out <= fields.test_mode;
      mode_word_out <= mode_r;
      col_spacing_out <= spacing_nxt;
    end
  end
endmodule

/* sim/ddrmr_asserts.sv */
// Concurrent checks on the mode register top, bound to every instance.
// Assumes clk_en held high and each command driven whole in one cycle.
`timescale 1ns/1ps
module ddrmr_asserts #(
  parameter int LOCK_CYCLES = 512
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic [2:0] bank_addr,
  input wire ddrmr_pkg::ddrmr_word_t addr_pins,
  input wire logic precharge_pd,
  input wire logic active_pd,
  input wire logic [1:0] burst_mode_out,
  input wire logic [4:0] read_latency_out,
  input wire ddrmr_pkg::ddrmr_word_t mode_word_out,
  input wire logic cmd_valid_out,
  input wire logic cmd_burst_eight_out,
  input wire logic data_start_out,
  input wire logic loop_restart_out,
  input wire logic loop_locked_out,
  input wire logic loop_frozen_out
);
  import ddrmr_pkg::*;
  logic [19:0] rd_hist_r;
  logic [4:0] quiet_r;
  int lock_cnt_r;
  wire col_pin = !chip_sel_n && row_strobe_n && !col_strobe_n;
  wire rd_pin = col_pin && write_en_n;
  wire ms_pin = !chip_sel_n && !row_strobe_n && !col_strobe_n && !write_en_n && bank_addr == 3'h0;
  wire lat_armed = quiet_r > read_latency_out + 5'h07;
  // Read history, cycles since a mode set, unfrozen cycles since a loop restart
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_hist_r <= '0;
      quiet_r <= 5'h00;
      lock_cnt_r <= 0;
    end else begin
      rd_hist_r <= {rd_hist_r[18:0], rd_pin};
      quiet_r <= ms_pin ? 5'h00 : quiet_r + {4'h0, quiet_r != 5'h1f};
      lock_cnt_r <= loop_restart_out ? 0 : lock_cnt_r + (loop_frozen_out ? 0 : 1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence burst_held(logic [1:0] m);
    col_pin && burst_mode_out == m ##1 (burst_mode_out == m)[*3];
  endsequence
  a_word_load: assert property (ms_pin |-> ##4 mode_word_out == $past(addr_pins, 4))
    else $error("mode word not loaded from pins");
  a_restart_clear: assert property (ms_pin && addr_pins[8] |->
    ##4 loop_restart_out ##1 !loop_restart_out && !mode_word_out[8])
    else $error("loop restart bit did not pulse and clear");
  a_lock_time: assert property ($rose(loop_locked_out) |-> lock_cnt_r == LOCK_CYCLES)
    else $error("loop lock came at the wrong time");
  a_data_first: assert property (data_start_out && lat_armed |-> rd_hist_r[read_latency_out + 5'h01])
    else $error("read data start without a read at latency");
  a_data_due: assert property (lat_armed && rd_hist_r[read_latency_out + 5'h01] |-> data_start_out)
    else $error("read data start missing at latency");
  a_eight_fixed: assert property (burst_held(2'h0) |-> cmd_valid_out && cmd_burst_eight_out)
    else $error("fixed eight mode gave a chop");
  a_chop_fixed: assert property (burst_held(2'h2) |-> cmd_valid_out && !cmd_burst_eight_out)
    else $error("fixed chop mode gave eight");
  a_otf_size: assert property (burst_held(2'h1) |-> cmd_burst_eight_out == $past(addr_pins[12], 3))
    else $error("per command size not taken from bit 12");
  a_pd_frozen: assert property ((precharge_pd && !active_pd && !mode_word_out[12])[*3] |-> loop_frozen_out)
    else $error("loop not frozen in slow precharge power-down");
  a_active_live: assert property (active_pd [*2] |-> !loop_frozen_out)
    else $error("loop frozen in active power-down");
  c_data: cover property (data_start_out);
  c_lock: cover property ($rose(loop_locked_out));
  c_frozen: cover property (loop_frozen_out);
endmodule
bind ddrmr_top ddrmr_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_asserts (.*);

/* sim/ddrmr_ctrl_model.sv */
// Controller model issuing mode sets and column commands to the mode register top.
// Assumes it shares core_clk with the design and that the bench calls its tasks.
`timescale 1ns/1ps
module ddrmr_ctrl_model (
  input wire logic core_clk,
  input wire logic loop_locked_out,
  output logic chip_sel_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_en_n,
  output logic [2:0] bank_addr,
  output ddrmr_pkg::ddrmr_word_t addr_pins
);
  import ddrmr_pkg::*;
  task automatic drive(input logic [3:0] c, input logic [2:0] b, input ddrmr_word_t a);
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} <= c;
    bank_addr <= b;
    addr_pins <= a;
  endtask
  initial drive(4'hf, 3'h7, 14'h0000);
  // One command cycle, then deselect with the lines inverted
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input ddrmr_word_t a);
    @(posedge core_clk);
    drive(c, b, a);
    @(posedge core_clk);
    drive(4'hf, ~b, ~a);
  endtask
  task automatic mode_set(input logic [2:0] b, input ddrmr_word_t a);
    issue(4'h0, b, a & 14'h1f7f);
  endtask
  task automatic init_seq(input ddrmr_word_t a);
    mode_set(3'h0, a | 14'h0100);
  endtask
  // Reads wait for the loop to lock, under a bound
  task automatic column(input logic wr, input logic a12);
    for (int i = 0; i < 999 && !wr && loop_locked_out !== 1'b1; i++) @(posedge core_clk);
    issue({3'h2, !wr}, 3'h0, {1'b0, a12, 12'h000});
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the mode register top with a controller model.
// Assumes a 10 MHz clock and a short lock count.
`timescale 1ns/1ps
module tb_top;
  import ddrmr_pkg::*;
  typedef struct packed {logic [3:0] cl; logic [4:0] lat; logic [2:0] wr; logic [4:0] rec;}
    ddrmr_row_t;
  localparam int LOCK = 8;
  ddrmr_row_t rows [14] = '{
    '{4'h2, 5'h05, 3'h0, 5'h10}, '{4'h4, 5'h06, 3'h1, 5'h05}, '{4'h6, 5'h07, 3'h2, 5'h06},
    '{4'h8, 5'h08, 3'h3, 5'h07}, '{4'ha, 5'h09, 3'h4, 5'h08}, '{4'hc, 5'h0a, 3'h5, 5'h0c},
    '{4'he, 5'h0b, 3'h7, 5'h0e}, '{4'h1, 5'h0c, 3'h0, 5'h10}, '{4'h3, 5'h0d, 3'h1, 5'h05},
    '{4'h5, 5'h0f, 3'h2, 5'h06}, '{4'h9, 5'h10, 3'h3, 5'h07}, '{4'h7, 5'h09, 3'h4, 5'h08},
    '{4'h0, 5'h09, 3'h5, 5'h0c}, '{4'hf, 5'h09, 3'h6, 5'h10}};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic precharge_pd = 1'b0;
  logic active_pd = 1'b0;
  logic chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic [2:0] bank_addr, col_spacing_out;
  ddrmr_word_t addr_pins, mode_word_out;
  logic [1:0] burst_mode_out;
  logic [4:0] read_latency_out, write_recovery_out;
  logic read_interleave_out, test_mode_out, cmd_valid_out, cmd_is_write_out, cmd_burst_eight_out;
  logic data_start_out, data_burst_eight_out, loop_restart_out, loop_locked_out, read_early_out;
  logic loop_frozen_out, slow_exit_out;
  int n_errors = 0;
  int n_checks = 0;
  wire logic [2:0] evt = {cmd_valid_out, loop_locked_out, loop_restart_out};
  ddrmr_top #(.LOCK_CYCLES(LOCK)) uut (.*);
  ddrmr_ctrl_model ctl (.*);
  initial forever #50 core_clk = ~core_clk;
  task automatic stop_test;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_on(input int k, input int lim);
    int i;
    for (i = 0; i < lim && evt[k] !== 1'b1; i++) tick(1);
    if (i == lim) begin
      n_errors++;
      $display("Error at %0t: wait %h timed out after %h cycles", $time, k, lim);
      stop_test();
    end
  endtask
  task automatic chk_fields(input ddrmr_word_t w, input logic [4:0] lat, input logic [4:0] rec);
    chk(16'(mode_word_out), 16'(w));
    chk(16'(read_latency_out), 16'(lat));
    chk(16'(write_recovery_out), 16'(rec));
    chk(16'(burst_mode_out), 16'(w[1:0]));
    chk(16'(read_interleave_out), 16'(w[3]));
    chk(16'(col_spacing_out), w[1:0] == 2'h2 ? 16'h0004 : 16'h0000);
    chk(16'(test_mode_out), 16'h0000);
  endtask
  initial begin
    ddrmr_word_t w;
    int n;
    logic e;
    logic [1:0] m;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    tick(3);
    chk_fields(14'h0050, 5'h09, 5'h10);
    foreach (rows[i]) begin
      w = {2'h0, rows[i].wr, 2'h0, rows[i].cl[3:1], 1'(i), rows[i].cl[0], 2'(i)};
      ctl.mode_set(3'h0, w);
      tick(5);
      chk_fields(w, rows[i].lat, rows[i].rec);
    end
    ctl.mode_set(3'h1, 14'h0004);
    ctl.mode_set(3'h4, 14'h0004);
    tick(5);
    chk(16'(mode_word_out), 16'(w));
    ctl.init_seq(14'h0010);
    wait_on(0, 10);
    chk(16'(loop_locked_out), 16'h0000);
    tick(2);
    chk(16'(mode_word_out), 16'h0010);
    wait_on(1, LOCK + 10);
    for (int k = 0; k < 8; k++) begin
      m = 2'((k / 2) ^ (k / 4));
      ctl.mode_set(3'h0, {12'h004, m});
      tick(5);
      e = (m == 2'h1) ? k[0] : (m != 2'h2);
      ctl.column(1'b0, k[0]);
      wait_on(2, 10);
      chk(16'(cmd_burst_eight_out), 16'(e));
      n = 0;
      while (data_start_out !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      chk(16'(n), 16'h0004);
      chk(16'(data_burst_eight_out), 16'(e));
    end
    ctl.column(1'b1, 1'b1);
    wait_on(2, 10);
    chk(16'({cmd_is_write_out, cmd_burst_eight_out}), 16'h0002);
    chk(16'(read_early_out), 16'h0000);
    @(posedge core_clk);
    precharge_pd <= 1'b1;
    tick(3);
    chk(16'({loop_frozen_out, slow_exit_out}), 16'h0003);
    @(posedge core_clk);
    active_pd <= 1'b1;
    tick(3);
    chk(16'(loop_frozen_out), 16'h0000);
    @(posedge core_clk);
    active_pd <= 1'b0;
    ctl.mode_set(3'h0, 14'h1010);
    tick(5);
    chk(16'({loop_frozen_out, slow_exit_out}), 16'h0000);
    @(posedge core_clk);
    precharge_pd <= 1'b0;
    reset <= 1'b1;
    tick(3);
    @(posedge core_clk);
    reset <= 1'b0;
    tick(3);
    chk_fields(14'h0050, 5'h09, 5'h10);
    chk(16'(loop_locked_out), 16'h0000);
    // Read before any lock is flagged
    ctl.issue(4'h5, 3'h0, 14'h0000);
    tick(4);
    chk(16'({read_early_out, loop_locked_out}), 16'h0002);
    stop_test();
  end
endmodule
